// ===== common/crx_consts.svh
`ifndef CRX_CONSTS_SVH
`define CRX_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CRX_ADDR_FLAG    8'h00
`define CRX_ADDR_IEN     8'h04
`define CRX_ADDR_CTL     8'h08

// ------------------------------------------------------------
// Flag / enable field positions (shared layout)
// ------------------------------------------------------------
`define CRX_B_WAKE       7
`define CRX_B_CSC        6
`define CRX_RS_HI        5
`define CRX_RS_LO        4
`define CRX_TS_HI        3
`define CRX_TS_LO        2
`define CRX_B_OVR        1
`define CRX_B_RXF        0

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CRX_C_INIT_REQUEST     0
`define CRX_C_SLEEP_REQUEST      1
`define CRX_C_WUPEN      2
`define CRX_C_INIT_ACKNOWLEDGE     4
`define CRX_C_SLEEP_ACKNOWLEDGE      5

// ------------------------------------------------------------
// Error counter limits and state codes
// ------------------------------------------------------------
`define CRX_WRN_LIM      9'h060
`define CRX_ERR_LIM      9'h07F
`define CRX_BOFF_LIM     9'h0FF
`define CRX_CODE_OK      2'h0
`define CRX_CODE_WRN     2'h1
`define CRX_CODE_ERR     2'h2
`define CRX_CODE_BOFF    2'h3

// ------------------------------------------------------------
// Sensitivity selections and reset values
// ------------------------------------------------------------
`define CRX_SENS_ALL     2'h3
`define CRX_SENS_ERR     2'h2
`define CRX_SENS_BOFF    2'h1
`define CRX_SENS_NONE    2'h0
`define CRX_BIT_RST      1'b0
`define CRX_CTL_RST      3'h0
`define CRX_WORD_ZERO    32'h0000_0000

`endif

// ===== common/crx_pkg.sv
// ------------------------------------------------------------
// Shared types
// ------------------------------------------------------------
`default_nettype none
package crx_pkg;
  typedef logic [1:0] crx_code_t;
  typedef logic [8:0] crx_tec_t;
  typedef logic [7:0] crx_rec_t;
endpackage : crx_pkg
`default_nettype wire

// ===== common/crx_enc_if.sv
`timescale 1ns/1ns
`default_nettype none
// Counters in, raw state codes out
interface crx_enc_if;
  crx_pkg::crx_tec_t  transmit_error_counter;
  crx_pkg::crx_rec_t  receive_error_counter;
  crx_pkg::crx_code_t tx_raw;
  crx_pkg::crx_code_t rx_raw;
  modport enc  (input transmit_error_counter, receive_error_counter, output tx_raw, rx_raw);
  modport user (output transmit_error_counter, receive_error_counter, input tx_raw, rx_raw);
endinterface : crx_enc_if
`default_nettype wire

// ===== src/crx_state_enc.sv
`timescale 1ns/1ns
`default_nettype none
`include "crx_consts.svh"
module crx_state_enc (
  // Counter values and codes
  crx_enc_if.enc bus
);
  // ------------------------------------------------------------
  // Transmitter code from its counter
  // ------------------------------------------------------------
  function automatic crx_pkg::crx_code_t tx_code(input crx_pkg::crx_tec_t c);
    if (c > `CRX_BOFF_LIM) begin
      tx_code = `CRX_CODE_BOFF;
    end else if (c > `CRX_ERR_LIM) begin
      tx_code = `CRX_CODE_ERR;
    end else if (c > `CRX_WRN_LIM) begin
      tx_code = `CRX_CODE_WRN;
    end else begin
      tx_code = `CRX_CODE_OK;
    end
  endfunction : tx_code

  // R8 - transmitter code bands
  assign bus.tx_raw = tx_code(bus.transmit_error_counter);

  // R7 - receiver code, bus-off mirrored from transmitter
  always_comb begin
    if (bus.tx_raw == `CRX_CODE_BOFF) begin
      bus.rx_raw = `CRX_CODE_BOFF;
    end else if ({1'b0, bus.receive_error_counter} > `CRX_ERR_LIM) begin
      bus.rx_raw = `CRX_CODE_ERR;
    end else if ({1'b0, bus.receive_error_counter} > `CRX_WRN_LIM) begin
      bus.rx_raw = `CRX_CODE_WRN;
    end else begin
      bus.rx_raw = `CRX_CODE_OK;
    end
  end
endmodule : crx_state_enc
`default_nettype wire

// ===== src/crx_flag_irq.sv
// Functional notes
// R1 - Flags clear only by writing one once cause ended; zero writes ignored.
// R2 - Init mode holds flag register reset; writes accepted only after it.
// R3 - State codes and sensitivity fields survive init; codes read-only.
// R4 - Wake flag sets on bus activity in sleep with wake-up enabled.
// R5 - Status-change flag sets on error-state change per sensitivity.
// R6 - Pending status-change flag freezes both state codes.
// R7 - Receiver code: OK to 96, warning to 127, error above, bus-off.
// R8 - Transmitter code: OK to 96, warning, error to 255, bus-off above.
// R9 - Transmitter leaving bus-off forces receiver code to OK.
// R10 - Overrun flag sets on every receive overrun.
// R11 - Receive-full sets when a valid message enters foreground buffer.
// R12 - No foreground reload while receive-full is set.
// R13 - Software clears receive-full after reading the message.
// R14 - Software avoids reading receive buffer while receive-full clear.
// R15 - Init mode holds interrupt enables reset; writes only after it.
// R16 - Wake interrupt while wake flag and its enable set.
// R17 - Error interrupt from status-change or overrun with own enable.
// R18 - Receive interrupt while receive-full and its enable set.
// R19 - Receiver sensitivity: all, error/bus-off, bus-off only, never.
// R20 - Transmitter sensitivity: all, error/bus-off, bus-off only, never.
// R21 - Software sets wake interrupt enable and wake-up control together.
// R22 - Init mode active only with request and acknowledge both one.
// R23 - Sleep mode active only with request and acknowledge both one.
// R24 - Counters, overrun, reception and activity come from engine.
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "crx_consts.svh"
module crx_flag_irq (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         srst_in,
  // AHB-Lite slave
  input  wire logic         hsel_in,
  input  wire logic [31:0]  haddr_in,
  input  wire logic [1:0]   htrans_in,
  input  wire logic         hwrite_in,
  input  wire logic [2:0]   hsize_in,
  input  wire logic [31:0]  hwdata_in,
  input  wire logic         hready_in,
  output logic              hreadyout_out,
  output logic              hresp_out,
  output logic [31:0]       hrdata_out,
  // Protocol engine side
  input  wire logic [8:0]   tec_in,
  input  wire logic [7:0]   rec_in,
  input  wire logic         overrun_pulse_in,
  input  wire logic         rx_msg_pending_in,
  input  wire logic         bus_activity_in,
  input  wire logic         init_acknowledge_in,
  input  wire logic         sleep_acknowledge_in,
  output logic              fg_load_out,
  output logic              init_request_out,
  output logic              sleep_request_out,
  output logic              wakeup_enable_ctl_out,
  // Interrupt requests
  output logic              wake_irq_out,
  output logic              error_irq_out,
  output logic              rx_irq_out
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic               wake_flag_reg;
  logic               status_change_flag_reg;
  logic               overrun_flag_reg;
  logic               receive_full_flag_reg;
  crx_pkg::crx_code_t rx_state_code_reg;
  crx_pkg::crx_code_t tx_state_code_reg;
  logic               wake_irq_enable_reg;
  logic               status_change_irq_enable_reg;
  logic               overrun_irq_enable_reg;
  logic               receive_full_irq_enable_reg;
  crx_pkg::crx_code_t rx_state_sensitivity_reg;
  crx_pkg::crx_code_t tx_state_sensitivity_reg;
  logic               init_request_reg;
  logic               sleep_request_reg;
  logic               wakeup_enable_ctl_reg;
  logic               dp_write_reg;
  logic [7:0]         dp_addr_reg;
  logic [31:0]        hrdata_reg;

  logic               init_mode;
  logic               sleep_mode;
  logic               ap_take;
  logic               wr_flag;
  logic               wr_ien;
  logic               wr_ctl;
  logic               wake_set;
  logic               csc_set;
  logic               code_upd;
  crx_pkg::crx_code_t rx_code_next;
  logic [7:0]         receiver_flag_reg;
  logic [7:0]         receiver_irq_enable_reg;
  logic [7:0]         ctl_word;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // R19 R20 - sensitivity filter for one code transition
  function automatic logic sens_hit(input crx_pkg::crx_code_t sens,
                                    input crx_pkg::crx_code_t old_c,
                                    input crx_pkg::crx_code_t new_c);
    logic diff;
    diff = (old_c != new_c);
    unique case (sens)
      `CRX_SENS_ALL:  sens_hit = diff;
      `CRX_SENS_ERR:  sens_hit = diff && (old_c[1] || new_c[1]);
      `CRX_SENS_BOFF: sens_hit = diff && (old_c == `CRX_CODE_BOFF ||
                                          new_c == `CRX_CODE_BOFF);
      `CRX_SENS_NONE: sens_hit = 1'b0;
    endcase
  endfunction : sens_hit

  // Byte address match on the low eight bits, upper address bits ignored
  function automatic logic reg_sel(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_sel = (a == off);
  endfunction : reg_sel

  // ------------------------------------------------------------
  // Counter to state code encoder
  // ------------------------------------------------------------
  crx_enc_if enc_bus ();
  // R24 - engine counters feed the encoder
  assign enc_bus.transmit_error_counter = tec_in;
  assign enc_bus.receive_error_counter = rec_in;
  crx_state_enc u_enc (
    .bus (enc_bus.enc)
  );

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  // R22 - init needs request and acknowledge
  assign init_mode  = init_request_reg && init_acknowledge_in;
  // R23 - sleep needs request and acknowledge
  assign sleep_mode = sleep_request_reg && sleep_acknowledge_in;

  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ------------------------------------------------------------
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_reg;
  assign ap_take       = hsel_in && htrans_in[1] && hready_in;
  assign wr_flag = dp_write_reg && reg_sel(dp_addr_reg, `CRX_ADDR_FLAG);
  assign wr_ien  = dp_write_reg && reg_sel(dp_addr_reg, `CRX_ADDR_IEN);
  assign wr_ctl  = dp_write_reg && reg_sel(dp_addr_reg, `CRX_ADDR_CTL);

  // Address phase capture for the following data phase
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else if (hready_in) begin
      dp_write_reg <= ap_take && hwrite_in;
      dp_addr_reg  <= haddr_in[7:0];
    end
  end

  // Read data sampled at address phase; unmapped reads as zero
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      hrdata_reg <= `CRX_WORD_ZERO;
    end else if (ap_take && !hwrite_in) begin
      if (reg_sel(haddr_in[7:0], `CRX_ADDR_FLAG)) begin
        hrdata_reg <= {24'h000000, receiver_flag_reg};
      end else if (reg_sel(haddr_in[7:0], `CRX_ADDR_IEN)) begin
        hrdata_reg <= {24'h000000, receiver_irq_enable_reg};
      end else if (reg_sel(haddr_in[7:0], `CRX_ADDR_CTL)) begin
        hrdata_reg <= {24'h000000, ctl_word};
      end else begin
        hrdata_reg <= `CRX_WORD_ZERO;
      end
    end
  end

  // ------------------------------------------------------------
  // Register read images
  // ------------------------------------------------------------
  assign receiver_flag_reg = {wake_flag_reg, status_change_flag_reg,
                              rx_state_code_reg, tx_state_code_reg,
                              overrun_flag_reg, receive_full_flag_reg};
  assign receiver_irq_enable_reg = {wake_irq_enable_reg,
                                    status_change_irq_enable_reg,
                                    rx_state_sensitivity_reg,
                                    tx_state_sensitivity_reg,
                                    overrun_irq_enable_reg,
                                    receive_full_irq_enable_reg};
  assign ctl_word = {2'h0, sleep_acknowledge_in, init_acknowledge_in,
                     1'b0, wakeup_enable_ctl_reg, sleep_request_reg,
                     init_request_reg};

  // ------------------------------------------------------------
  // Mode control register, writable at any time
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      {wakeup_enable_ctl_reg, sleep_request_reg, init_request_reg} <=
        `CRX_CTL_RST;
    end else if (wr_ctl) begin
      init_request_reg      <= hwdata_in[`CRX_C_INIT_REQUEST];
      sleep_request_reg     <= hwdata_in[`CRX_C_SLEEP_REQUEST];
      wakeup_enable_ctl_reg <= hwdata_in[`CRX_C_WUPEN];
    end
  end
  assign init_request_out      = init_request_reg;
  assign sleep_request_out     = sleep_request_reg;
  assign wakeup_enable_ctl_out = wakeup_enable_ctl_reg;

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  // R4 - wake on activity in sleep when enabled
  assign wake_set = sleep_mode && bus_activity_in && wakeup_enable_ctl_reg;
  // R12 - foreground reload only while receive-full clear
  assign fg_load_out = rx_msg_pending_in && !receive_full_flag_reg &&
                       !init_mode;
  // R6 - codes follow the counters only while no change is pending
  assign code_upd = !status_change_flag_reg;

  // R9 - leaving bus-off drops receiver straight to OK
  always_comb begin
    if (tx_state_code_reg == `CRX_CODE_BOFF &&
        enc_bus.tx_raw != `CRX_CODE_BOFF) begin
      rx_code_next = `CRX_CODE_OK;
    end else begin
      rx_code_next = enc_bus.rx_raw;
    end
  end

  // R5 - flag a change that passes either sensitivity filter
  assign csc_set = code_upd && !init_mode &&
    (sens_hit(rx_state_sensitivity_reg, rx_state_code_reg, rx_code_next) ||
     sens_hit(tx_state_sensitivity_reg, tx_state_code_reg,
              enc_bus.tx_raw));

  // ------------------------------------------------------------
  // State codes, untouched by init and not software writable
  // ------------------------------------------------------------
  // R3 - only the counters move these
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rx_state_code_reg <= `CRX_CODE_OK;
      tx_state_code_reg <= `CRX_CODE_OK;
    end else if (code_upd) begin
      rx_state_code_reg <= rx_code_next;
      tx_state_code_reg <= enc_bus.tx_raw;
    end
  end

  // ------------------------------------------------------------
  // Sticky flags; set beats a same-cycle clear
  // ------------------------------------------------------------
  // R2 - init holds flags reset; R1 - write one clears, zero ignored
  always_ff @(posedge mclk_in) begin
    if (srst_in || init_mode) begin
      wake_flag_reg <= `CRX_BIT_RST;
    end else if (wake_set) begin
      wake_flag_reg <= 1'b1;
    end else if (wr_flag && hwdata_in[`CRX_B_WAKE]) begin
      wake_flag_reg <= 1'b0;
    end
  end

  // R5 - status change flag
  always_ff @(posedge mclk_in) begin
    if (srst_in || init_mode) begin
      status_change_flag_reg <= `CRX_BIT_RST;
    end else if (csc_set) begin
      status_change_flag_reg <= 1'b1;
    end else if (wr_flag && hwdata_in[`CRX_B_CSC]) begin
      status_change_flag_reg <= 1'b0;
    end
  end

  // R10 - overrun flag
  always_ff @(posedge mclk_in) begin
    if (srst_in || init_mode) begin
      overrun_flag_reg <= `CRX_BIT_RST;
    end else if (overrun_pulse_in) begin
      overrun_flag_reg <= 1'b1;
    end else if (wr_flag && hwdata_in[`CRX_B_OVR]) begin
      overrun_flag_reg <= 1'b0;
    end
  end

  // R11 - receive-full on foreground reload; R13 cleared by software
  always_ff @(posedge mclk_in) begin
    if (srst_in || init_mode) begin
      receive_full_flag_reg <= `CRX_BIT_RST;
    end else if (fg_load_out) begin
      receive_full_flag_reg <= 1'b1;
    end else if (wr_flag && hwdata_in[`CRX_B_RXF]) begin
      receive_full_flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Interrupt enables
  // ------------------------------------------------------------
  // R15 - init holds enables reset, writes only outside init
  always_ff @(posedge mclk_in) begin
    if (srst_in || init_mode) begin
      wake_irq_enable_reg          <= `CRX_BIT_RST;
      status_change_irq_enable_reg <= `CRX_BIT_RST;
      overrun_irq_enable_reg       <= `CRX_BIT_RST;
      receive_full_irq_enable_reg  <= `CRX_BIT_RST;
    end else if (wr_ien) begin
      wake_irq_enable_reg          <= hwdata_in[`CRX_B_WAKE];
      status_change_irq_enable_reg <= hwdata_in[`CRX_B_CSC];
      overrun_irq_enable_reg       <= hwdata_in[`CRX_B_OVR];
      receive_full_irq_enable_reg  <= hwdata_in[`CRX_B_RXF];
    end
  end

  // R3 - sensitivity survives init, still write-locked during it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rx_state_sensitivity_reg <= `CRX_SENS_NONE;
      tx_state_sensitivity_reg <= `CRX_SENS_NONE;
    end else if (wr_ien && !init_mode) begin
      rx_state_sensitivity_reg <= hwdata_in[`CRX_RS_HI:`CRX_RS_LO];
      tx_state_sensitivity_reg <= hwdata_in[`CRX_TS_HI:`CRX_TS_LO];
    end
  end

  // ------------------------------------------------------------
  // Interrupt requests, levels from flag and enable flops
  // ------------------------------------------------------------
  // R16 - wake request
  assign wake_irq_out  = wake_flag_reg && wake_irq_enable_reg;
  // R17 - error request from either source
  assign error_irq_out =
    (status_change_flag_reg && status_change_irq_enable_reg) ||
    (overrun_flag_reg && overrun_irq_enable_reg);
  // R18 - receive request
  assign rx_irq_out    = receive_full_flag_reg && receive_full_irq_enable_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_fg_load_en;
    fg_load_out && receive_full_irq_enable_reg && !wr_ien && !init_mode;
  endsequence
  sequence s_flag_zero_wr;
    wr_flag && !hwdata_in[`CRX_B_RXF] && receive_full_flag_reg && !init_mode;
  endsequence

  a_init_flags_held: assert property ( // R2
    init_mode |=> !wake_flag_reg && !status_change_flag_reg &&
                  !overrun_flag_reg && !receive_full_flag_reg)
    else $error("flag set while init mode active");
  a_init_ien_held: assert property ( // R15
    init_mode |=> !wake_irq_enable_reg && !receive_full_irq_enable_reg)
    else $error("interrupt enable set during init mode");
  a_wake_on_act: assert property ( // R4
    wake_set && !init_mode |=> wake_flag_reg ##1
      (wake_flag_reg || $past(wr_flag) || $past(init_mode)))
    else $error("wake flag missed bus activity");
  a_codes_frozen: assert property ( // R6
    status_change_flag_reg && !wr_flag |=> $stable(rx_state_code_reg) &&
                                           $stable(tx_state_code_reg))
    else $error("state code moved while change pending");
  a_tx_code_follow: assert property ( // R8
    code_upd ##1 1'b1 |-> tx_state_code_reg == $past(enc_bus.tx_raw))
    else $error("transmitter code not tracking counter");
  a_boff_exit_ok: assert property ( // R9
    code_upd && tx_state_code_reg == `CRX_CODE_BOFF &&
    tec_in <= `CRX_BOFF_LIM |=> rx_state_code_reg == `CRX_CODE_OK)
    else $error("receiver code not OK after bus-off exit");
  a_ovr_set: assert property ( // R10
    overrun_pulse_in && !init_mode |=> overrun_flag_reg)
    else $error("overrun flag not set");
  a_rxf_blocks: assert property ( // R12
    receive_full_flag_reg |-> !fg_load_out)
    else $error("foreground reload while receive-full set");
  a_rx_irq_load: assert property ( // R18
    s_fg_load_en |=> rx_irq_out)
    else $error("receive interrupt missing after reload");
  a_zero_wr_keeps: assert property ( // R1
    s_flag_zero_wr |=> receive_full_flag_reg)
    else $error("zero write cleared receive-full");
  a_err_irq_ovr: assert property ( // R17
    overrun_flag_reg && overrun_irq_enable_reg |-> error_irq_out)
    else $error("error request missing for overrun");
  a_csc_on_boff: assert property ( // R20
    code_upd && !init_mode && tx_state_sensitivity_reg != `CRX_SENS_NONE &&
    tx_state_code_reg != `CRX_CODE_BOFF && tec_in > `CRX_BOFF_LIM
    |=> status_change_flag_reg)
    else $error("bus-off entry not flagged");

endmodule : crx_flag_irq
`default_nettype wire

// ===== dv/crx_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Protocol engine stand-in
// ------------------------------------------------------------
module crx_engine_model (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  // Bench commands
  input  wire logic [8:0] tec_cmd_in,
  input  wire logic [7:0] rec_cmd_in,
  input  wire logic       ovr_cmd_in,
  input  wire logic       msg_cmd_in,
  input  wire logic       act_cmd_in,
  // Device side
  input  wire logic       init_request_in,
  input  wire logic       sleep_request_in,
  input  wire logic       fg_load_in,
  output logic [8:0]      tec_out,
  output logic [7:0]      rec_out,
  output logic            overrun_pulse_out,
  output logic            rx_msg_pending_out,
  output logic            bus_activity_out,
  output logic            init_acknowledge_out,
  output logic            sleep_acknowledge_out
);
  always_ff @(posedge mclk_in) begin
    tec_out           <= srst_in ? 9'h000 : tec_cmd_in;
    rec_out           <= srst_in ? 8'h00 : rec_cmd_in;
    overrun_pulse_out <= ~srst_in & ovr_cmd_in;
    bus_activity_out  <= ~srst_in & act_cmd_in;
  end
  // only good frames wait, dropped once loaded
  always_ff @(posedge mclk_in) begin
    rx_msg_pending_out <= ~srst_in
                          & (msg_cmd_in | (rx_msg_pending_out & ~fg_load_in));
  end
  // acknowledges lag requests by a cycle
  always_ff @(posedge mclk_in) begin
    init_acknowledge_out  <= ~srst_in & init_request_in;
    sleep_acknowledge_out <= ~srst_in & sleep_request_in;
  end
endmodule : crx_engine_model
`default_nettype wire

// ===== dv/crx_flag_irq_tb.sv
`timescale 1ns/1ns
`default_nettype none
module crx_flag_irq_tb;
  // ------------------------------------------------------------
  // Bench signals, bus master held selected with word size
  // ------------------------------------------------------------
  logic        mclk = 1'b0, srst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [8:0]  transmit_error_counter, tec_c = 9'h000;
  logic [7:0]  receive_error_counter, rec_c = 8'h00;
  logic        ovr_c = 1'b0, msg_c = 1'b0, act_c = 1'b0;
  logic        hrdy, hresp, ovr, pend, act, iack, sack, fgl;
  logic        ireq, sreq, wen, wirq, eirq, rirq;
  int          fail_count = 0, n_checks = 0;

  crx_flag_irq uut (.mclk_in(mclk), .srst_in(srst), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
    .tec_in(transmit_error_counter), .rec_in(receive_error_counter), .overrun_pulse_in(ovr),
    .rx_msg_pending_in(pend), .bus_activity_in(act),
    .init_acknowledge_in(iack), .sleep_acknowledge_in(sack),
    .fg_load_out(fgl), .init_request_out(ireq), .sleep_request_out(sreq),
    .wakeup_enable_ctl_out(wen), .wake_irq_out(wirq),
    .error_irq_out(eirq), .rx_irq_out(rirq));
  crx_engine_model eng (.mclk_in(mclk), .srst_in(srst), .tec_cmd_in(tec_c),
    .rec_cmd_in(rec_c), .ovr_cmd_in(ovr_c), .msg_cmd_in(msg_c),
    .act_cmd_in(act_c), .init_request_in(ireq), .sleep_request_in(sreq),
    .fg_load_in(fgl), .tec_out(transmit_error_counter), .rec_out(receive_error_counter),
    .overrun_pulse_out(ovr), .rx_msg_pending_out(pend),
    .bus_activity_out(act), .init_acknowledge_out(iack),
    .sleep_acknowledge_out(sack));

  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded wait for hready, never assumes zero wait states
  task automatic hwait;
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask : hwait

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] r);
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    hwait();
    r = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 8'h00, r);
    chk(nm, {24'h00_0000, e}, r);
  endtask : rdc

  // One-cycle engine event: overrun, frame, activity
  task automatic pls(input logic [2:0] k);
    {ovr_c, msg_c, act_c} <= k;
    @(posedge mclk);
    {ovr_c, msg_c, act_c} <= 3'h0;
    repeat (3) @(posedge mclk);
  endtask : pls

  // Counters (op 0), flag write (1) or enable write (2), then flags
  task automatic st(input int op, input logic [8:0] a, input logic [7:0] b,
                    input logic [7:0] e);
    if (op == 0) begin
      tec_c <= a;
      rec_c <= b;
    end else begin
      wr(op == 1 ? 8'h00 : 8'h04, a[7:0]);
    end
    repeat (4) @(posedge mclk);
    rdc("flags", 8'h00, e);
  endtask : st

  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rdc("flag", 8'h00, 8'h00);
    rdc("ien", 8'h04, 8'h00);
    rdc("ctl", 8'h08, 8'h00);
    rdc("unmapped", 8'h0C, 8'h00);
    wr(8'h04, 8'hFF);
    rdc("ien", 8'h04, 8'hFF);
    // Second frame must wait behind a full foreground buffer
    pls(3'h2);
    pls(3'h2);
    rdc("flag", 8'h00, 8'h01);
    chk("irqs", 32'h1, 32'({wirq, eirq, rirq}));
    chk("fg_load", 32'h0, 32'(fgl));
    wr(8'h00, 8'hFE);
    rdc("flag", 8'h00, 8'h01);
    wr(8'h00, 8'h01);
    // Next frame loads one edge after the clear, then pending drops
    repeat (2) @(posedge mclk);
    chk("pending", 32'h0, 32'(pend));
    wr(8'h04, 8'hFE);
    @(posedge mclk);
    chk("irqs", 32'h0, 32'({wirq, eirq, rirq}));
    st(1, 9'h001, 8'h00, 8'h00);
    pls(3'h4);
    chk("irqs", 32'h2, 32'({wirq, eirq, rirq}));
    st(1, 9'h002, 8'h00, 8'h00);
    // Error-state walk under several sensitivities
    st(2, 9'h04C, 8'h00, 8'h00);
    st(0, 9'd0, 8'd97, 8'h10);
    st(0, 9'd97, 8'd97, 8'h54);
    chk("irqs", 32'h2, 32'({wirq, eirq, rirq}));
    st(0, 9'd200, 8'd97, 8'h54);
    st(1, 9'h040, 8'h00, 8'h58);
    st(1, 9'h040, 8'h00, 8'h18);
    st(2, 9'h064, 8'h00, 8'h18);
    st(0, 9'd200, 8'd128, 8'h68);
    st(1, 9'h040, 8'h00, 8'h28);
    st(0, 9'd300, 8'd128, 8'h7C);
    st(1, 9'h040, 8'h00, 8'h3C);
    st(0, 9'd0, 8'd128, 8'h40);
    st(1, 9'h040, 8'h00, 8'h60);
    // Initialization mode
    wr(8'h08, 8'h01);
    // Acknowledge lags a cycle, flags clear one edge later
    repeat (2) @(posedge mclk);
    rdc("flag", 8'h00, 8'h20);
    rdc("ien", 8'h04, 8'h24);
    wr(8'h04, 8'hFF);
    rdc("ien", 8'h04, 8'h24);
    rdc("ctl", 8'h08, 8'h11);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'hC3);
    rdc("ien", 8'h04, 8'hC3);
    // Sleep and wake-up
    pls(3'h1);
    rdc("flag", 8'h00, 8'h20);
    wr(8'h08, 8'h06);
    @(posedge mclk);
    chk("wen", 32'h1, 32'(wen));
    rdc("ctl", 8'h08, 8'h26);
    pls(3'h1);
    rdc("flag", 8'h00, 8'hA0);
    chk("irqs", 32'h4, 32'({wirq, eirq, rirq}));
    st(1, 9'h080, 8'h00, 8'h20);
    test_done();
  end
endmodule : crx_flag_irq_tb
`default_nettype wire
